// file: bench/ivs_core_model.sv
`default_nettype none
module ivs_core_model (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Request from the controller, delay before taking it
	input  wire ivs_pkg::ivs_core_req_t core_req,
	input  wire logic [3:0]             ack_delay,
	output logic                        core_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	ivs_pkg::ivs_core_req_t log_q[$];
	logic [3:0]             wait_cnt;

	// Take a standing request after the chosen delay; log it at the edge the ack is seen
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_ack <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (core_ack)
		begin
			core_ack <= 1'b0;
			wait_cnt <= 4'h0;
			log_q.push_back(core_req);
		end
		else if (core_req.valid && wait_cnt >= ack_delay)
			core_ack <= 1'b1;
		else if (core_req.valid)
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule
`default_nettype wire

// file: bench/ivs_top_test.sv
`default_nettype none
module ivs_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, core_ack, err;
	logic                   fast_internal_rc_osc;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic [3:0]             pstrb, ack_delay;
	logic [117:0]           src_req;
	logic [7:0]             trap_req;
	logic [2:0]             cpu_level;
	logic [23:0]            reset_pc;
	ivs_pkg::ivs_core_req_t core_req, req_nb;
	ivs_pkg::ivs_clkmon_t   clock_failure_monitor;
	int                     fails, comparisons, cycles, c;
	logic [11:0]            cfg_a [10] = '{12'h040, 12'h044, 12'h04C, 12'h05C, 12'h100,
		12'h104, 12'h108, 12'h114, 12'h13C, 12'h174};
	logic [31:0]            cfg_d [10] = '{32'h022C, 32'h0010, 32'h1000, 32'h0020, 32'h5300,
		32'h0040, 32'h0040, 32'h0006, 32'h0002, 32'h0010};

	ivs_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .src_req, .trap_req, .cpu_level, .core_ack, .core_req, .reset_pc,
		.clock_failure_monitor, .fast_internal_rc_osc);
	// Same stimulus, no boot segment
	ivs_top #(.HAS_BOOT_SEG(1'b0)) u_dut_nb (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb, .prdata(), .pready(), .pslverr(), .src_req, .trap_req, .cpu_level,
		.core_ack, .core_req(req_nb), .reset_pc(), .clock_failure_monitor, .fast_internal_rc_osc());
	ivs_core_model u_core (.pclk, .presetn, .core_req, .ack_delay, .core_ack);

	always #5 pclk = ~pclk;

	// Cut a hang short
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; data taken at the edge that sees pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 40)
		begin
			@(posedge pclk);
			n++;
		end
		// A slave that never answers counts as a mismatch
		if (n == 40)
			fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [117:0] s, input logic [7:0] t);
		@(posedge pclk);
		src_req <= s;
		trap_req <= t;
		@(posedge pclk);
		src_req <= '0;
		trap_req <= '0;
	endtask

	// Edges from the sampling of an event to the request standing
	task automatic lat;
		c = 0;
		@(negedge pclk);
		while (core_req.valid !== 1'b1 && c < 20)
		begin
			c++;
			@(negedge pclk);
		end
	endtask

	task automatic quiet;
		repeat (6) @(negedge pclk);
		check(core_req.valid, 1'b0);
	endtask

	// Compare the next request taken by the core
	task automatic take(input logic tr, input logic [6:0] num, input logic [23:0] a);
		int n;
		ivs_pkg::ivs_core_req_t q;
		n = 0;
		while (u_core.log_q.size() == 0 && n < 50)
		begin
			@(negedge pclk);
			n++;
		end
		q = (u_core.log_q.size() != 0) ? u_core.log_q.pop_front() : '0;
		check(q.addr, a);
		check({q.trap, q.number}, {tr, num});
	endtask

	// Main sequence
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{src_req, trap_req, cpu_level, ack_delay, clock_failure_monitor} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check(reset_pc, 24'h000000);
		check(core_req.valid, 1'b0);
		apb(1'b0, ivs_pkg::OFF_CTRL2, 32'h0);
		check(rd, 32'h0000);
		apb(1'b0, 12'h3F0, 32'h0);
		check(rd, 32'h00000000);
		check(err, 1'b1);
		pulse(118'h1 << 4, 8'h00);
		quiet();
		apb(1'b0, ivs_pkg::OFF_FLAG, 32'h0);
		check(rd, 32'h0010);
		for (int i = 0; i < 10; i++)
			apb(1'b1, cfg_a[i], cfg_d[i]);
		apb(1'b0, 12'h100, 32'h0);
		check(rd, 32'h5300);
		pulse(118'h1 << 3, 8'h00);
		lat();
		check(c, 1);
		take(1'b0, 7'd3, 24'h00001A);
		ack_delay <= 4'hF;
		pulse(118'h1 << 60, 8'h00);
		lat();
		check(c, 1);
		apb(1'b0, ivs_pkg::OFF_VADDR, 32'h0);
		check(rd, 32'h0000008C);
		apb(1'b0, ivs_pkg::OFF_STAT, 32'h0);
		check(rd, 32'h0000823C);
		take(1'b0, 7'd60, 24'h00008C);
		ack_delay <= 4'h4;
		pulse((118'h1 << 5) | (118'h1 << 9), 8'h00);
		take(1'b0, 7'd5, 24'h00001E);
		take(1'b0, 7'd9, 24'h000026);
		ack_delay <= 4'h0;
		pulse((118'h1 << 2) | (118'h1 << 20), 8'h00);
		take(1'b0, 7'd20, 24'h00003C);
		take(1'b0, 7'd2, 24'h000018);
		@(posedge pclk);
		cpu_level <= 3'd5;
		pulse(118'h1 << 3, 8'h00);
		quiet();
		@(posedge pclk);
		cpu_level <= 3'd4;
		take(1'b0, 7'd3, 24'h00001A);
		@(posedge pclk);
		cpu_level <= 3'd0;
		for (int n = 0; n < 8; n++)
		begin
			pulse('0, 8'h01 << n);
			if (ivs_pkg::TRAP_IMPL[n])
				take(1'b1, 7'(n), 24'h000004 + 24'(2 * n));
			else
				quiet();
		end
		// Reserved trap bits cannot be set by software either
		apb(1'b1, ivs_pkg::OFF_TRAP, 32'h00A0);
		apb(1'b0, ivs_pkg::OFF_TRAP, 32'h0);
		check(rd, 32'h00000000);
		pulse(118'h1 << 20, 8'h40);
		take(1'b1, 7'd6, 24'h000010);
		take(1'b0, 7'd20, 24'h00003C);
		apb(1'b1, ivs_pkg::OFF_ALTBASE, 32'h0400);
		apb(1'b1, ivs_pkg::OFF_CTRL2, 32'h0100);
		apb(1'b0, ivs_pkg::OFF_CTRL2, 32'h0);
		check(rd, 32'h0100);
		pulse(118'h1 << 117, 8'h00);
		lat();
		check(req_nb.addr, 24'h0000FE);
		take(1'b0, 7'd117, 24'h0004FE);
		pulse('0, 8'h02);
		take(1'b1, 7'd1, 24'h000406);
		apb(1'b1, ivs_pkg::OFF_CTRL2, 32'h0);
		clock_failure_monitor <= 3'b010;
		quiet();
		check(fast_internal_rc_osc, 1'b0);
		@(posedge pclk);
		clock_failure_monitor <= 3'b100;
		@(posedge pclk);
		clock_failure_monitor <= 3'b110;
		repeat (2) @(negedge pclk);
		check(fast_internal_rc_osc, 1'b1);
		take(1'b1, 7'd0, 24'h000004);
		// Software reselects the crystal after the fallback
		apb(1'b0, ivs_pkg::OFF_CLKMON, 32'h0);
		check(rd, 32'h00000001);
		apb(1'b1, ivs_pkg::OFF_CLKMON, 32'h0);
		apb(1'b0, ivs_pkg::OFF_CLKMON, 32'h0);
		check(rd, 32'h00000000);
		end_of_test();
	end
endmodule
`default_nettype wire

// file: core/ivs_pkg.sv
`default_nettype none
package ivs_pkg;
	// Sizes of the vector map and the source set
	localparam int ADDR_W = 24;
	localparam int NUM_SRC_DEF = 118;
	localparam int NUM_TRAP = 8;
	localparam int NUM_LEVELS = 7;
	localparam int SRC_PER_FLAG = 16;
	localparam int SRC_PER_PRIO = 4;
	localparam int PRIO_FIELD = 4;
	localparam int PADDR_W = 12;

	// Fixed program memory locations, word addresses
	localparam logic [ADDR_W-1:0] RESET_PC = 24'h000000;
	localparam logic [ADDR_W-1:0] TRAP_BASE = 24'h000004;
	localparam logic [ADDR_W-1:0] INT_BASE = 24'h000014;
	localparam logic [ADDR_W-1:0] ALT_BASE_RESET = 24'h000000;

	// Implemented traps: 5 and 7 are reserved
	localparam logic [NUM_TRAP-1:0] TRAP_IMPL = 8'h5F;
	localparam int TRAP_OSC_FAIL = 0;

	// Control word two field
	localparam int ALT_SEL_BIT = 8;
	localparam logic [15:0] CTRL2_RESET = 16'h0000;
	localparam logic [15:0] CTRL2_MASK = 16'h0100;

	// Register byte offsets on the bus
	localparam logic [PADDR_W-1:0] OFF_FLAG = 12'h000;
	localparam logic [PADDR_W-1:0] OFF_EN = 12'h040;
	localparam logic [PADDR_W-1:0] OFF_PRIO = 12'h100;
	localparam logic [PADDR_W-1:0] OFF_CTRL2 = 12'h200;
	localparam logic [PADDR_W-1:0] OFF_ALTBASE = 12'h204;
	localparam logic [PADDR_W-1:0] OFF_TRAP = 12'h208;
	localparam logic [PADDR_W-1:0] OFF_STAT = 12'h20C;
	localparam logic [PADDR_W-1:0] OFF_VADDR = 12'h210;
	localparam logic [PADDR_W-1:0] OFF_CLKMON = 12'h214;

	// Request toward the processor core
	typedef struct packed {
		logic              valid;
		logic              trap;
		logic [6:0]        number;
		logic [2:0]        level;
		logic [ADDR_W-1:0] addr;
	} ivs_core_req_t;

	// Clock-failure monitor inputs
	typedef struct packed {
		logic enable;
		logic master_reset_release;
		logic clock_valid;
	} ivs_clkmon_t;
endpackage
`default_nettype wire

// file: core/ivs_top.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`default_nettype none
module ivs_top #(
	parameter int         NUM_SRC = ivs_pkg::NUM_SRC_DEF,
	parameter logic       HAS_BOOT_SEG = 1'b1
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic [ivs_pkg::PADDR_W-1:0]   paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Event sources
	input  wire logic [NUM_SRC-1:0]            src_req,
	input  wire logic [ivs_pkg::NUM_TRAP-1:0]  trap_req,
	// Processor core side
	input  wire logic [2:0]                    cpu_level,
	input  wire logic                          core_ack,
	output var ivs_pkg::ivs_core_req_t         core_req,
	output logic      [ivs_pkg::ADDR_W-1:0]    reset_pc,
	// Clock-failure monitor
	input  wire ivs_pkg::ivs_clkmon_t          clock_failure_monitor,
	output logic                               fast_internal_rc_osc
);
	localparam int NFW = (NUM_SRC + ivs_pkg::SRC_PER_FLAG - 1) / ivs_pkg::SRC_PER_FLAG;
	localparam int NPW = (NUM_SRC + ivs_pkg::SRC_PER_PRIO - 1) / ivs_pkg::SRC_PER_PRIO;

	logic [NUM_SRC-1:0]           pending_flag;
	logic [NUM_SRC-1:0]           source_enable;
	logic [2:0]                   priority_field [NUM_SRC];
	logic [15:0]                  interrupt_control_word_two;
	logic [ivs_pkg::ADDR_W-1:0]   alternate_table_base;
	logic [ivs_pkg::NUM_TRAP-1:0] trap_pending;
	logic                         release_seen;
	logic [NUM_SRC-1:0]           next_pending;
	logic [ivs_pkg::NUM_TRAP-1:0] next_trap;
	ivs_pkg::ivs_core_req_t       next_req;
	logic [31:0]                  next_rdata;
	logic                         next_err;
	logic [2:0]                   best_lvl;
	logic [6:0]                   best_idx;
	logic                         trap_hit;
	logic [2:0]                   trap_idx;
	logic                         alt_on;
	logic [ivs_pkg::ADDR_W-1:0]   table_base;
	logic [5:0]                   widx;
	logic                         in_flag;
	logic                         in_en;
	logic                         in_prio;
	logic                         wr_acc;
	logic [15:0]                  wmask;
	logic [15:0]                  wdat;
	logic                         taken;
	logic                         clock_lost;

	// Bus decode: word index and region hits
	assign widx = paddr[7:2];
	assign in_flag = (paddr[11:6] == ivs_pkg::OFF_FLAG[11:6]) && (int'(widx) < NFW);
	assign in_en = (paddr[11:6] == ivs_pkg::OFF_EN[11:6]) && (int'(widx[3:0]) < NFW); // Word index inside the region
	assign in_prio = (paddr[11:8] == ivs_pkg::OFF_PRIO[11:8]) && (int'(widx) < NPW);
	assign wr_acc = psel && penable && pready && pwrite;
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wdat = pwdata[15:0];
	assign taken = core_ack && core_req.valid;

	// Table choice; alternate table needs a boot segment
	assign alt_on = interrupt_control_word_two[ivs_pkg::ALT_SEL_BIT] && HAS_BOOT_SEG;
	assign table_base = alt_on ? alternate_table_base : ivs_pkg::RESET_PC;

	// Monitor fires once, on the release edge, when no clock is seen
	assign clock_lost = clock_failure_monitor.enable && clock_failure_monitor.master_reset_release
		&& !release_seen && !clock_failure_monitor.clock_valid;

	// Pending flags: source sets beat software and core clears
	always_comb
	begin
		next_pending = pending_flag;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (wr_acc && in_flag && paddr[11:6] == ivs_pkg::OFF_FLAG[11:6]
				&& i / 16 == int'(widx) && wmask[i % 16])
			begin
				next_pending[i] = wdat[i % 16];
			end
			if (taken && !core_req.trap && int'(core_req.number) == i)
			begin
				next_pending[i] = 1'b0;
			end
			if (src_req[i])
			begin
				next_pending[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending_flag <= '0;
		else
			pending_flag <= next_pending;
	end

	// Enable bits, one per source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			source_enable <= '0;
		else
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (wr_acc && in_en && i / 16 == int'(widx[3:0]) && wmask[i % 16])
					source_enable[i] <= wdat[i % 16];
			end
		end
	end

	// Three-bit priority fields, four to a word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_SRC; i++)
				priority_field[i] <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (wr_acc && in_prio && i / 4 == int'(widx) && wmask[(i % 4) * 4])
					priority_field[i] <= wdat[(i % 4) * 4 +: 3];
			end
		end
	end

	// Control word two and alternate base
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			interrupt_control_word_two <= ivs_pkg::CTRL2_RESET;
			alternate_table_base <= ivs_pkg::ALT_BASE_RESET;
		end
		else if (wr_acc)
		begin
			if (paddr == ivs_pkg::OFF_CTRL2)
				interrupt_control_word_two <= (interrupt_control_word_two & ~(wmask & ivs_pkg::CTRL2_MASK))
					| (wdat & wmask & ivs_pkg::CTRL2_MASK);
			if (paddr == ivs_pkg::OFF_ALTBASE)
			begin
				for (int b = 0; b < 3; b++)
				begin
					if (pstrb[b])
						alternate_table_base[b * 8 +: 8] <= pwdata[b * 8 +: 8];
				end
			end
		end
	end

	// Trap pending: hardware and monitor sets win over clears
	always_comb
	begin
		next_trap = trap_pending;
		if (wr_acc && paddr == ivs_pkg::OFF_TRAP && pstrb[0])
			next_trap = pwdata[7:0];
		if (taken && core_req.trap)
			next_trap[core_req.number[2:0]] = 1'b0;
		next_trap = next_trap | trap_req;
		if (clock_lost)
			next_trap[ivs_pkg::TRAP_OSC_FAIL] = 1'b1;
		next_trap = next_trap & ivs_pkg::TRAP_IMPL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trap_pending <= '0;
		else
			trap_pending <= next_trap;
	end

	// Clock-failure monitor: edge memory and RC fallback
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			release_seen <= 1'b0;
			fast_internal_rc_osc <= 1'b0;
		end
		else
		begin
			release_seen <= clock_failure_monitor.master_reset_release;
			if (clock_lost)
				fast_internal_rc_osc <= 1'b1;
			else if (wr_acc && paddr == ivs_pkg::OFF_CLKMON && pstrb[0])
				fast_internal_rc_osc <= pwdata[0];
		end
	end

	// Arbitration: highest level, lowest number on ties
	always_comb
	begin
		best_lvl = 3'h0;
		best_idx = 7'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pending_flag[i] && source_enable[i] && priority_field[i] != 3'h0
				&& priority_field[i] >= best_lvl)
			begin
				best_lvl = priority_field[i];
				best_idx = 7'(i);
			end
		end
		trap_hit = 1'b0;
		trap_idx = 3'h0;
		for (int t = ivs_pkg::NUM_TRAP - 1; t >= 0; t--)
		begin
			if (trap_pending[t])
			begin
				trap_hit = 1'b1;
				trap_idx = 3'(t);
			end
		end
	end

	// Build the request and its vector address
	always_comb
	begin
		next_req = '0;
		if (trap_hit)
		begin
			next_req.valid = 1'b1;
			next_req.trap = 1'b1;
			next_req.number = {4'h0, trap_idx};
			next_req.level = 3'h7;
			next_req.addr = table_base + ivs_pkg::TRAP_BASE + 24'({trap_idx, 1'b0});
		end
		else if (best_lvl > cpu_level)
		begin
			next_req.valid = 1'b1;
			next_req.number = best_idx;
			next_req.level = best_lvl;
			next_req.addr = table_base + ivs_pkg::INT_BASE + 24'({best_idx, 1'b0});
		end
	end

	// Core request register; an acknowledge blanks it for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_req <= '0;
			reset_pc <= ivs_pkg::RESET_PC;
		end
		else
		begin
			reset_pc <= ivs_pkg::RESET_PC;
			if (taken)
				core_req <= '0;
			else
				core_req <= next_req;
		end
	end

	// Read data and unmapped detection
	always_comb
	begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		if (in_flag || in_en)
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (i / 16 == int'(widx[3:0]))
					next_rdata[i % 16] = in_flag ? pending_flag[i] : source_enable[i];
			end
		end
		else if (in_prio)
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (i / 4 == int'(widx))
					next_rdata[(i % 4) * 4 +: 3] = priority_field[i];
			end
		end
		else if (paddr == ivs_pkg::OFF_CTRL2)
			next_rdata[15:0] = interrupt_control_word_two;
		else if (paddr == ivs_pkg::OFF_ALTBASE)
			next_rdata[23:0] = alternate_table_base;
		else if (paddr == ivs_pkg::OFF_TRAP)
			next_rdata[7:0] = trap_pending;
		else if (paddr == ivs_pkg::OFF_STAT)
			next_rdata[15:0] = {core_req.valid, core_req.trap, 1'b0, 2'b00, core_req.level, 1'b0, core_req.number};
		else if (paddr == ivs_pkg::OFF_VADDR)
			next_rdata[23:0] = core_req.addr;
		else if (paddr == ivs_pkg::OFF_CLKMON)
			next_rdata[0] = fast_internal_rc_osc;
		else
			next_err = 1'b1;
	end

	// APB answer: one wait-free access cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h00000000;
			pslverr <= psel && !penable && next_err;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_trap_wins: assert property (trap_hit && !taken |=> core_req.valid && core_req.trap)
		else $error("pending trap not presented");
	a_int_level: assert property (core_req.valid && !core_req.trap |-> core_req.level > $past(cpu_level))
		else $error("interrupt level not above core level");
	a_level_nonzero: assert property (core_req.valid && !core_req.trap |-> core_req.level != 3'h0)
		else $error("level zero source presented");
	a_int_primary: assert property (core_req.valid && !core_req.trap && !$past(alt_on)
		|-> core_req.addr == ivs_pkg::INT_BASE + 24'({core_req.number, 1'b0}))
		else $error("primary interrupt vector address wrong");
	a_trap_primary: assert property (core_req.valid && core_req.trap && !$past(alt_on)
		|-> core_req.addr == ivs_pkg::TRAP_BASE + 24'({core_req.number[2:0], 1'b0}))
		else $error("primary trap vector address wrong");
	a_int_alt: assert property (core_req.valid && !core_req.trap && $past(alt_on)
		|-> core_req.addr == $past(alternate_table_base) + ivs_pkg::INT_BASE + 24'({core_req.number, 1'b0}))
		else $error("alternate interrupt vector address wrong");
	a_ack_blank: assert property (taken |=> !core_req.valid ##1 core_req.valid == $past(next_req.valid))
		else $error("acknowledge latency not fixed");
	a_src_sets: assert property (src_req != '0 |=> (pending_flag & $past(src_req)) == $past(src_req))
		else $error("source request lost");
	a_clk_fallback: assert property (clock_lost |=> fast_internal_rc_osc && trap_pending[ivs_pkg::TRAP_OSC_FAIL]
		##1 ((core_req.valid && core_req.trap) || $past(taken)))
		else $error("clock failure fallback missing");
	a_reserved_trap: assert property (trap_pending[5] == 1'b0 && trap_pending[7] == 1'b0)
		else $error("reserved trap pending");
endmodule
`default_nettype wire
